// ==== shared/hbs_pkg.sv ====
package hbs_pkg;
	// Command frame layout
	localparam int FRAME_BITS   = 16;
	localparam int CMD_ADDR_LSB = 12;
	localparam int CMD_WD_BIT   = 11;
	localparam int CMD_DATA_W   = 11;
	// Command register addresses
	localparam logic [3:0] ADDR_CTRL0     = 4'h0;
	localparam logic [3:0] ADDR_CFG_FIRST = 4'h5;
	localparam logic [3:0] ADDR_CFG_LAST  = 4'ha;
	localparam logic [3:0] ADDR_TEST_CUR  = 4'hc;
	localparam logic [3:0] ADDR_DEGLITCH  = 4'he;
	localparam logic [3:0] ADDR_FACTORY   = 4'hf;
	// Field positions inside the 11 data bits
	localparam int CFG_SEL_BIT = 10;
	localparam int MODE_BIT    = 10;
	localparam int PTR_LSB     = 7;
	localparam int THR_LSB     = 7;
	localparam int DLY_LSB     = 3;
	localparam int SLEW_LSB    = 0;
	localparam int LS_TEST_LSB = 4;
	localparam int HS_TEST_LSB = 0;
	localparam int THR_W       = 3;
	localparam int DLY_W       = 4;
	localparam int SLEW_W      = 3;
	localparam int CFG_W       = THR_W + DLY_W + SLEW_W;
	localparam int TEST_W      = 3;
	// Reply frame layout
	localparam int STAT_W      = 12;
	// Status word selection codes
	typedef enum logic [2:0] {
		SEL_DEV  = 3'h0,
		SEL_GATE = 3'h1,
		SEL_OVL  = 3'h3,
		SEL_CAL  = 3'h4,
		SEL_OUT  = 3'h5,
		SEL_ID   = 3'h7
	} hbs_sel_e;
	// Device status bit positions
	localparam int DS_TM   = 11;
	localparam int DS_RCF  = 10;
	localparam int DS_FS   = 9;
	localparam int DS_FRAME_ERROR_FLAG = 8;
	localparam int DS_CPL  = 7;
	localparam int DS_CPF  = 6;
	localparam int DS_UV   = 5;
	localparam int DS_OV   = 4;
	localparam int DS_SUM  = 1;
	localparam int CAL_RDY_BIT = 8;
	localparam int CAL_RES_W   = 8;
	// Reset values
	localparam logic [CFG_W-1:0]      CFG_RST  = 10'h000;
	localparam logic [TEST_W-1:0]     TEST_RST = 3'h0;
	localparam logic                  MODE_RST = 1'b0;
	localparam logic [2:0]            PTR_RST  = 3'h0;
	localparam logic [CMD_DATA_W-1:0] FTW_RST  = 11'h000;
endpackage : hbs_pkg

// ==== sim/hbs_chk.sv ====
`timescale 1ns/1ps
// Port-level checks of the register block
module hbs_chk
	import hbs_pkg::*;
#(
	parameter int NCH = 6
) (
	input wire logic                  i_clk,
	input wire logic                  i_rst_b,
	input wire logic                  i_ce,
	input wire logic                  i_csb,
	input wire logic                  i_pump_fail,
	input wire logic                  o_miso,
	input wire logic [NCH*THR_W-1:0]  o_overload_threshold_code,
	input wire logic [NCH*DLY_W-1:0]  o_detect_delay_code,
	input wire logic [NCH*SLEW_W-1:0] o_slew_current_code,
	input wire logic [TEST_W-1:0]     o_low_side_test_enable,
	input wire logic [TEST_W-1:0]     o_high_side_test_enable,
	input wire logic [NCH-1:0]        o_deglitch_type_select,
	input wire logic [CMD_DATA_W-1:0] o_factory_test_word,
	input wire logic                  o_watchdog_toggle_bit,
	input wire logic                  o_high_side_block
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	logic [NCH*(CFG_W+1)+17:0] cfg_all;
	logic [4:0]                idle_q;
	// All host-written outputs in one vector
	assign cfg_all = {o_overload_threshold_code, o_detect_delay_code, o_slew_current_code,
		o_low_side_test_enable, o_high_side_test_enable, o_deglitch_type_select,
		o_factory_test_word, o_watchdog_toggle_bit};
	// Cycles since chip select went high, saturating so it never wraps
	always_ff @(posedge i_clk) begin
		if (!i_rst_b || !i_csb)
			idle_q <= 5'h00;
		else if (idle_q != 5'h1f)
			idle_q <= idle_q + 5'h01;
	end
	chk_block_set: assert property (i_pump_fail && i_ce |-> ##[1:4] o_high_side_block)
		else $error("pump fault did not block high side");
	chk_block_cause: assert property ($rose(o_high_side_block) |-> $past(i_pump_fail, 3))
		else $error("high side block without pump fault");
	chk_block_hold: assert property (o_high_side_block && idle_q > 5'h0a |=> o_high_side_block)
		else $error("pump flag dropped without a read");
	chk_block_clear: assert property ($fell(o_high_side_block) |-> !$past(i_pump_fail, 3))
		else $error("pump flag cleared while fault present");
	chk_cfg_reset: assert property (disable iff (1'b0) !i_rst_b |=> cfg_all == '0)
		else $error("config not zero after reset");
	chk_ctl_reset: assert property (disable iff (1'b0) !i_rst_b ##1 !i_rst_b |-> !o_high_side_block)
		else $error("block flag set in reset");
	chk_cfg_idle: assert property (idle_q > 5'h0a |-> $stable(cfg_all))
		else $error("config changed with no frame");
	chk_miso_idle: assert property (i_csb && $past(i_csb) |-> !o_miso)
		else $error("reply line driven while deselected");
	cover property ($rose(o_high_side_block));
	cover property ($fell(o_high_side_block));
	cover property ($changed(cfg_all));
endmodule : hbs_chk
bind hbs_regs hbs_chk #(.NCH(NCH)) u_chk (.i_clk, .i_rst_b, .i_ce, .i_csb, .i_pump_fail,
	.o_miso, .o_overload_threshold_code, .o_detect_delay_code, .o_slew_current_code,
	.o_low_side_test_enable, .o_high_side_test_enable, .o_deglitch_type_select,
	.o_factory_test_word, .o_watchdog_toggle_bit, .o_high_side_block);

// ==== sim/hbs_host.sv ====
`timescale 1ns/1ps
// Host link master: clock idles low, bits go out on rise, come in on fall
module hbs_host (
	output logic      o_sclk,
	output logic      o_csb,
	output logic      o_mosi,
	input  wire logic i_miso
);
	initial begin
		o_sclk = 1'b0;
		o_csb = 1'b1;
		o_mosi = 1'b0;
	end
	// One frame of n bits, MSB first; n below 16 makes a short frame
	task automatic xfer(input logic [15:0] cmd, input int n, output logic [15:0] rsp);
		rsp = 16'h0000;
		o_csb = 1'b0;
		#37;
		for (int k = 15; k > 15 - n; k--) begin
			o_sclk = 1'b1;
			o_mosi = cmd[k];
			#15;
			rsp = {rsp[14:0], i_miso}; // Taken just before the falling edge
			o_sclk = 1'b0;
			#15;
		end
		o_csb = 1'b1;
		o_mosi = ~o_mosi; // A released line must not keep its last bit
		#250; // Gap lets the reply word reload before the next frame
	endtask : xfer
endmodule : hbs_host

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import hbs_pkg::*;
	logic i_clk, i_rst_b, i_ce, i_sclk, i_csb, i_mosi, o_miso, i_normal_mode, i_failsafe;
	logic i_pump_low, i_pump_fail, i_supply_under, i_supply_over, i_cal_valid;
	logic o_watchdog_toggle_bit, o_high_side_block;
	logic [5:0]  i_high_gate, i_low_gate, i_high_ovl, i_low_ovl, o_deglitch_type_select;
	logic [7:0]  i_cal_result;
	logic [17:0] o_overload_threshold_code, o_slew_current_code;
	logic [23:0] o_detect_delay_code;
	logic [2:0]  o_low_side_test_enable, o_high_side_test_enable;
	logic [10:0] o_factory_test_word;
	logic [15:0] r, r1;
	int          mismatches, n_checks;
	// Command word beside the field value it should leave behind
	localparam logic [26:0] ROWS [10] = '{{16'h57ff, 11'h3ff}, {16'h5123, 11'h3ff},
		{16'h6c01, 11'h001}, {16'h7555, 11'h155}, {16'h8eaa, 11'h2aa}, {16'h95c7, 11'h1c7},
		{16'hae38, 11'h238}, {16'hc052, 11'h052}, {16'he02b, 11'h02b}, {16'hf6d9, 11'h6d9}};
	// Status pointer code beside the data it should return
	localparam logic [14:0] PTRS [5] = '{{3'h2, 12'h000}, {3'h4, 12'h19c}, {3'h5, 12'h000},
		{3'h6, 12'h000}, {3'h7, 12'h0c3}};
	// ID value is arbitrary
	hbs_regs #(.NCH(6), .ID_WORD(12'h0c3)) DUT (.i_clk, .i_rst_b, .i_ce, .i_sclk, .i_csb,
		.i_mosi, .o_miso, .i_normal_mode, .i_failsafe, .i_pump_low, .i_pump_fail,
		.i_supply_under, .i_supply_over, .i_high_gate, .i_low_gate, .i_high_ovl, .i_low_ovl,
		.i_cal_valid, .i_cal_result, .o_overload_threshold_code, .o_detect_delay_code,
		.o_slew_current_code, .o_low_side_test_enable, .o_high_side_test_enable,
		.o_deglitch_type_select, .o_factory_test_word, .o_watchdog_toggle_bit,
		.o_high_side_block);
	hbs_host u_host (.o_sclk(i_sclk), .o_csb(i_csb), .o_mosi(i_mosi), .i_miso(o_miso));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// Field read back by command address, in command bit order
	function automatic logic [10:0] rd(input logic [3:0] a);
		int n;
		n = int'(a) - 5;
		case (a)
			4'hc: rd = {4'h0, o_low_side_test_enable, 1'b0, o_high_side_test_enable};
			4'he: rd = {5'h00, o_deglitch_type_select};
			4'hf: rd = o_factory_test_word;
			default: rd = {1'b0, o_overload_threshold_code[3*n+:3],
				o_detect_delay_code[4*n+:4], o_slew_current_code[3*n+:3]};
		endcase
	endfunction : rd
	task automatic chk(input logic [83:0] got, input logic [83:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Inputs move one nanosecond after a rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick
	task automatic fx(input logic [15:0] c);
		u_host.xfer(c, 16, r);
	endtask : fx
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim
	initial begin
		#100000;
		mismatches++;
		end_sim();
	end
	initial begin
		{i_rst_b, i_normal_mode, i_failsafe, i_pump_low, i_pump_fail} = '0;
		{i_supply_under, i_supply_over, i_cal_valid, i_cal_result} = '0;
		{i_high_gate, i_low_gate, i_high_ovl, i_low_ovl} = '0;
		i_ce = 1'b1;
		mismatches = 0;
		n_checks = 0;
		tick(8);
		i_rst_b = 1'b1;
		tick(10);
		foreach (ROWS[i]) begin
			fx(ROWS[i][26:11]);
			chk(rd(ROWS[i][26:23]), ROWS[i][10:0]);
			chk(o_watchdog_toggle_bit, ROWS[i][22]);
		end
		// Second reset in mid-run must wipe the config, test enable and deglitch fields
		i_rst_b = 1'b0;
		tick(3);
		i_rst_b = 1'b1;
		tick(10);
		chk({o_overload_threshold_code, o_detect_delay_code, o_slew_current_code}, '0);
		chk({o_low_side_test_enable, o_high_side_test_enable, o_deglitch_type_select}, '0);
		// Raise the pump, supply and overload faults together, then take them away
		{i_normal_mode, i_failsafe, i_pump_low, i_pump_fail, i_supply_under, i_supply_over} = '1;
		i_high_ovl = 6'h04;
		i_low_ovl = 6'h01;
		tick(10);
		fx(16'hb000);
		fx(16'hb000);
		chk(r, 16'h16f2);
		chk(o_high_side_block, 1'b1);
		{i_pump_low, i_pump_fail, i_supply_under, i_supply_over, i_high_ovl, i_low_ovl} = '0;
		tick(10);
		fx(16'hb000);
		chk(r, 16'h12f2);
		chk(o_high_side_block, 1'b0);
		fx(16'h0580);
		chk(r, 16'h1202);
		fx(16'hb000);
		chk(r, 16'h7021);
		fx(16'hb000);
		chk(r, 16'h7000);
		i_high_gate = 6'h20;
		i_low_gate = 6'h01;
		fx(16'h0080);
		fx(16'hb000);
		chk(r, 16'h3801);
		fx(16'hb000);
		chk(r, 16'h1200);
		i_cal_result = 8'h9c;
		tick(2);
		i_cal_valid = 1'b1;
		tick(6);
		foreach (PTRS[i]) begin
			fx({6'h00, PTRS[i][14:12], 7'h00});
			chk(r, 16'h1200);
			fx(16'hb000);
			chk(r, {PTRS[i][14:12], 1'b1, PTRS[i][11:0]});
		end
		// A short frame must raise the frame error flag once
		u_host.xfer(16'hb000, 8, r1);
		fx(16'hb000);
		r1 = r;
		fx(16'hb000);
		chk(r1 | r, 16'h1300);
		fx(16'hb000);
		chk(r, 16'h1200);
		end_sim();
	end
endmodule : tb_top

// ==== src/hbs_regs.sv ====
`timescale 1ns/1ps
module hbs_regs
	import hbs_pkg::*;
#(
	parameter int          NCH     = 6,
	parameter logic [11:0] ID_WORD = 12'h5a3 // Arbitrary identity value
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_b,
	input  wire logic                   i_ce,
	input  wire logic                   i_sclk,
	input  wire logic                   i_csb,
	input  wire logic                   i_mosi,
	output logic                        o_miso,
	input  wire logic                   i_normal_mode,
	input  wire logic                   i_failsafe,
	input  wire logic                   i_pump_low,
	input  wire logic                   i_pump_fail,
	input  wire logic                   i_supply_under,
	input  wire logic                   i_supply_over,
	input  wire logic [NCH-1:0]         i_high_gate,
	input  wire logic [NCH-1:0]         i_low_gate,
	input  wire logic [NCH-1:0]         i_high_ovl,
	input  wire logic [NCH-1:0]         i_low_ovl,
	input  wire logic                   i_cal_valid,
	input  wire logic [CAL_RES_W-1:0]   i_cal_result,
	output logic [NCH*THR_W-1:0]        o_overload_threshold_code,
	output logic [NCH*DLY_W-1:0]        o_detect_delay_code,
	output logic [NCH*SLEW_W-1:0]       o_slew_current_code,
	output logic [TEST_W-1:0]           o_low_side_test_enable,
	output logic [TEST_W-1:0]           o_high_side_test_enable,
	output logic [NCH-1:0]              o_deglitch_type_select,
	output logic [CMD_DATA_W-1:0]       o_factory_test_word,
	output logic                        o_watchdog_toggle_bit,
	output logic                        o_high_side_block
);
	localparam int RAW_W = 4 * NCH + CAL_RES_W + 9;
	// Idle pin levels; chip select is high so reset fakes no edge
	localparam logic [RAW_W-1:0] SYNC_IDLE = {2'b01, {(RAW_W-2){1'b0}}};

	// Link side state
	logic [3:0]            cnt_p_q;
	logic [3:0]            cnt_n_q;
	logic [FRAME_BITS-2:0] sh_q;
	logic [FRAME_BITS-1:0] rx_q;
	logic                  tog_q;
	logic                  miso_q;
	// Core side state
	logic [FRAME_BITS-1:0] tx_word_q;
	logic [RAW_W-1:0]      s1_q;
	logic [RAW_W-1:0]      s2_q;
	logic                  tog_prev_q;
	logic                  csb_prev_q;
	logic                  got_q;
	logic                  load_q;
	logic                  mode_q;
	logic [2:0]            ptr_q;
	logic [CFG_W-1:0]      cfg_q [NCH];
	logic [TEST_W-1:0]     ls_test_q;
	logic [TEST_W-1:0]     hs_test_q;
	logic [NCH-1:0]        dgl_q;
	logic [CMD_DATA_W-1:0] ftw_q;
	logic                  wd_q;
	logic [3:0]            supply_q;
	logic                  frame_error_flag_q;
	logic                  rcf_q;
	logic                  nm_prev_q;
	logic [2*NCH-1:0]      gate_q;
	logic [2*NCH-1:0]      ovl_q;
	logic                  cal_rdy_q;
	logic                  cal_prev_q;
	logic [CAL_RES_W-1:0]  cal_res_q;

	// Shift out on rising clock so the host samples on falling;
	// the first rising edge already puts the MSB on the line.
	always_ff @(posedge i_sclk or posedge i_csb) begin
		if (i_csb) begin
			cnt_p_q <= 4'h0;
			miso_q  <= 1'b0;
		end else begin
			miso_q  <= tx_word_q[~cnt_p_q];
			cnt_p_q <= cnt_p_q + 4'h1;
		end
	end

	// Capture the command on falling clock edges
	always_ff @(negedge i_sclk or posedge i_csb) begin
		if (i_csb) begin
			cnt_n_q <= 4'h0;
			sh_q    <= '0;
		end else begin
			cnt_n_q <= cnt_n_q + 4'h1;
			sh_q    <= {sh_q[FRAME_BITS-3:0], i_mosi};
		end
	end

	// Word and toggle survive the chip select, so the core side
	// has the whole gap between frames to take the word.
	always_ff @(negedge i_sclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_q  <= '0;
			tog_q <= 1'b0;
		end else if (cnt_n_q == 4'hf) begin
			rx_q  <= {sh_q, i_mosi};
			tog_q <= ~tog_q;
		end
	end

	assign o_miso = miso_q;

	// Pins and the link toggle enter the core through two flops
	wire [RAW_W-1:0] raw_in = {tog_q, i_csb, i_normal_mode, i_failsafe,
		i_pump_low, i_pump_fail, i_supply_under, i_supply_over,
		i_cal_valid, i_cal_result, i_high_gate, i_low_gate,
		i_high_ovl, i_low_ovl};

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			s1_q <= SYNC_IDLE;
			s2_q <= SYNC_IDLE;
		end else if (i_ce) begin
			s1_q <= raw_in;
			s2_q <= s1_q;
		end
	end

	// Unpack the synchronised inputs
	wire                 tog_s = s2_q[RAW_W-1];
	wire                 csb_s = s2_q[RAW_W-2];
	wire                 nm_s  = s2_q[RAW_W-3];
	wire                 fs_s  = s2_q[RAW_W-4];
	wire [3:0]           sup_s = s2_q[RAW_W-5 -: 4];
	wire                 cv_s  = s2_q[RAW_W-9];
	wire [CAL_RES_W-1:0] cr_s  = s2_q[4*NCH +: CAL_RES_W];
	wire [NCH-1:0]       hg_s  = s2_q[3*NCH +: NCH];
	wire [NCH-1:0]       lg_s  = s2_q[2*NCH +: NCH];
	wire [NCH-1:0]       ho_s  = s2_q[NCH +: NCH];
	wire [NCH-1:0]       lo_s  = s2_q[0 +: NCH];

	// Frame events
	wire done     = tog_s ^ tog_prev_q;
	wire csb_rise = csb_s & ~csb_prev_q;
	wire csb_fall = ~csb_s & csb_prev_q;
	// A frame that ends without a whole word is a message failure
	wire err_now  = csb_rise & ~got_q & ~done;

	// Command decode
	wire [3:0]            cmd_addr = rx_q[FRAME_BITS-1:CMD_ADDR_LSB];
	wire [CMD_DATA_W-1:0] cmd_data = rx_q[CMD_DATA_W-1:0];
	wire                  cmd_wd   = rx_q[CMD_WD_BIT];
	wire wr_ctrl = done && (cmd_addr == ADDR_CTRL0);
	wire in_cfg  = (cmd_addr >= ADDR_CFG_FIRST) && (cmd_addr <= ADDR_CFG_LAST);
	wire wr_cfg  = done && in_cfg && cmd_data[CFG_SEL_BIT];
	wire wr_test = done && (cmd_addr == ADDR_TEST_CUR);
	wire wr_dgl  = done && (cmd_addr == ADDR_DEGLITCH);
	wire wr_ftw  = done && (cmd_addr == ADDR_FACTORY);
	wire [3:0] cfg_off = cmd_addr - ADDR_CFG_FIRST;
	wire [2:0] cfg_idx = cfg_off[2:0];

	// The word sent in the frame just ended counts as read
	wire [2:0] sent_ptr = tx_word_q[FRAME_BITS-1:STAT_W+1];
	wire rd_dev  = done && (sent_ptr == SEL_DEV);
	wire rd_gate = done && (sent_ptr == SEL_GATE);
	wire rd_ovl  = done && (sent_ptr == SEL_OVL);
	wire rd_cal  = done && (sent_ptr == SEL_CAL);

	// Frame bookkeeping
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			tog_prev_q <= 1'b0;
			csb_prev_q <= 1'b1;
			got_q      <= 1'b0;
		end else if (i_ce) begin
			tog_prev_q <= tog_s;
			csb_prev_q <= csb_s;
			got_q      <= done | (got_q & ~csb_fall);
		end
	end

	// Status pointer and read mode
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			mode_q <= MODE_RST;
			ptr_q  <= PTR_RST;
		end else if (i_ce) begin
			if (wr_ctrl) begin
				mode_q <= cmd_data[MODE_BIT];
				ptr_q  <= cmd_data[PTR_LSB +: 3];
			end else if (done && !mode_q) begin
				ptr_q  <= SEL_DEV;
			end
		end
	end

	// Configuration words
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			for (int i = 0; i < NCH; i++) begin
				cfg_q[i] <= CFG_RST;
			end
			ls_test_q <= TEST_RST;
			hs_test_q <= TEST_RST;
			dgl_q     <= '0;
			ftw_q     <= FTW_RST;
			wd_q      <= 1'b0;
		end else if (i_ce) begin
			if (wr_cfg) begin
				cfg_q[cfg_idx] <= cmd_data[CFG_W-1:0];
			end
			if (wr_test) begin
				ls_test_q <= cmd_data[LS_TEST_LSB +: TEST_W];
				hs_test_q <= cmd_data[HS_TEST_LSB +: TEST_W];
			end
			if (wr_dgl) begin
				dgl_q <= cmd_data[NCH-1:0];
			end
			if (wr_ftw) begin
				ftw_q <= cmd_data;
			end
			if (done) begin
				wd_q <= cmd_wd;
			end
		end
	end

	// Pack per-channel fields onto the output buses
	for (genvar g = 0; g < NCH; g++) begin : g_cfg
		assign o_overload_threshold_code[g*THR_W +: THR_W] = cfg_q[g][THR_LSB +: THR_W];
		assign o_detect_delay_code[g*DLY_W +: DLY_W]       = cfg_q[g][DLY_LSB +: DLY_W];
		assign o_slew_current_code[g*SLEW_W +: SLEW_W]     = cfg_q[g][SLEW_LSB +: SLEW_W];
	end

	assign o_low_side_test_enable  = ls_test_q;
	assign o_high_side_test_enable = hs_test_q;
	assign o_deglitch_type_select  = dgl_q;
	assign o_factory_test_word     = ftw_q;
	assign o_watchdog_toggle_bit   = wd_q;

	// Interleave high above low for each channel
	logic [2*NCH-1:0] gate_raw;
	logic [2*NCH-1:0] ovl_raw;
	always_comb begin
		gate_raw = '0;
		ovl_raw  = '0;
		for (int i = 0; i < NCH; i++) begin
			gate_raw[2*i+1] = hg_s[i];
			gate_raw[2*i]   = lg_s[i];
			ovl_raw[2*i+1]  = ho_s[i];
			ovl_raw[2*i]    = lo_s[i];
		end
	end

	// Latched diagnosis: a read clears only bits the host was shown
	// as one, so a fault raised after the snapshot is never lost.
	wire nm_rise  = nm_s & ~nm_prev_q;
	wire cal_rise = cv_s & ~cal_prev_q;
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			supply_q   <= 4'h0;
			frame_error_flag_q     <= 1'b0;
			gate_q     <= '0;
			ovl_q      <= '0;
			rcf_q      <= 1'b0;
			nm_prev_q  <= 1'b0;
			cal_rdy_q  <= 1'b0;
			cal_prev_q <= 1'b0;
			cal_res_q  <= '0;
		end else if (i_ce) begin
			supply_q   <= sup_s | (supply_q & ~({4{rd_dev}} & tx_word_q[DS_CPL -: 4]));
			frame_error_flag_q     <= err_now | (frame_error_flag_q & ~(rd_dev & tx_word_q[DS_FRAME_ERROR_FLAG]));
			gate_q     <= gate_raw | (gate_q & ~({2*NCH{rd_gate}} & tx_word_q[2*NCH-1:0]));
			ovl_q      <= ovl_raw | (ovl_q & ~({2*NCH{rd_ovl}} & tx_word_q[2*NCH-1:0]));
			rcf_q      <= nm_rise | (rcf_q & ~(rd_dev & tx_word_q[DS_RCF]));
			nm_prev_q  <= nm_s;
			cal_rdy_q  <= cal_rise | (cal_rdy_q & ~(rd_cal & tx_word_q[CAL_RDY_BIT]));
			cal_prev_q <= cv_s;
			if (cal_rise) begin
				cal_res_q <= cr_s;
			end
		end
	end

	// Summary of every overload flag
	wire ovl_sum = |ovl_q;
	// Pump fail flag itself is the block output, never a copy
	assign o_high_side_block = supply_q[2];

	// Device status word; test mode flag is always tied low
	wire [STAT_W-1:0] dev_word = {1'b0, rcf_q, fs_s, frame_error_flag_q,
		supply_q, 2'b00, ovl_sum, 1'b0};
	wire [STAT_W-1:0] cal_word = {3'b000, cal_rdy_q, cal_res_q};

	// Reply data selection; unused codes return zero
	wire [STAT_W-1:0] reply_data =
		(ptr_q == SEL_DEV)  ? dev_word :
		(ptr_q == SEL_GATE) ? gate_q :
		(ptr_q == SEL_OVL)  ? ovl_q :
		(ptr_q == SEL_CAL)  ? cal_word :
		(ptr_q == SEL_ID)   ? ID_WORD :
		12'h000;

	// Reply word is rebuilt one cycle after each complete frame, once the
	// pointer and read clears have settled, and held during frames.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			load_q    <= 1'b1;
			tx_word_q <= '0;
		end else if (i_ce) begin
			load_q <= done;
			if (load_q) begin
				tx_word_q <= {ptr_q, nm_s, reply_data};
			end
		end
	end
endmodule : hbs_regs
